// File: logic/pced_top.sv
// pin change edge detector: registers, ports, interrupt and wake logic
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pced_cfg.svh"
module pced_top #(
    parameter int PORT_W = 8
) (
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    input  wire pced_pkg::pced_pins_type   pins,
    input  wire pced_pkg::pced_bus_req_type bus_req,
    input  wire logic                      sleep_mode,
    output logic [`PCED_DATA_W-1:0]        rd_data,
    output logic                           change_irq,
    output logic                           wake_req,
    output logic                           evt_irq
);
    // the register bytes are exactly one port wide
    if (PORT_W != `PCED_DATA_W) begin : g_bad_w
        $error("pced_top: PORT_W must equal the data width");
    end

    // implemented pins of each port, port e has pin 3 only
    localparam pced_pkg::pced_port_arr_type PORT_MASK =
        {`PCED_MASK_E, `PCED_MASK_C, `PCED_MASK_B, `PCED_MASK_A};

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pced_pkg::pced_port_arr_type rise_en_reg;   // rising enables
    pced_pkg::pced_port_arr_type fall_en_reg;   // falling enables
    logic                        master_reg;    // master enable
    logic [`PCED_NEVT-1:0]       evt_stat_reg;  // sticky events
    logic [`PCED_NEVT-1:0]       evt_stat_next; // next events
    logic [`PCED_NEVT-1:0]       evt_en_reg;    // event enables
    logic [`PCED_DATA_W-1:0]     rd_data_reg;   // read answer
    logic                        change_irq_reg;// change request
    logic                        wake_reg;      // wake pulse
    logic                        evt_irq_reg;   // event irq

    // ------------------------------------------------------------
    // per-port datapath
    // ------------------------------------------------------------
    pced_pkg::pced_port_arr_type pin_vec;       // raw pins
    pced_pkg::pced_port_arr_type edge_arr;      // enabled edges
    pced_pkg::pced_port_arr_type flag_arr;      // sticky flags
    pced_pkg::pced_port_arr_type new_arr;       // newly set flags
    logic [`PCED_NEVT-1:0]       evt_set;       // per-port new flag

    // gather the pad pins into one byte per port
    assign pin_vec[0] = pins.a;
    assign pin_vec[1] = pins.b;
    assign pin_vec[2] = pins.c;
    // lone port e pin sits at its own bit position
    assign pin_vec[3] = `PCED_DATA_W'(pins.e3) << `PCED_E_PIN;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // port index and register group from the address
    wire [1:0] port_sel = bus_req.addr[1:0];
    wire [5:0] grp      = bus_req.addr[`PCED_ADDR_W-1:2];

    // group hits
    wire hit_rise  = (grp == `PCED_GRP_RISE);
    wire hit_fall  = (grp == `PCED_GRP_FALL);
    wire hit_flag  = (grp == `PCED_GRP_FLAG);
    wire hit_ctrl  = (bus_req.addr == `PCED_ADR_CTRL);
    wire hit_periph_int_request_reg0  = (bus_req.addr == `PCED_ADR_PERIPH_INT_REQUEST_REG0);
    wire hit_evst  = (bus_req.addr == `PCED_ADR_EVST);
    wire hit_evclr = (bus_req.addr == `PCED_ADR_EVCLR);
    wire hit_even  = (bus_req.addr == `PCED_ADR_EVEN);

    // write strobes per register
    wire wr_rise  = bus_req.wr && hit_rise;
    wire wr_fall  = bus_req.wr && hit_fall;
    wire wr_flag  = bus_req.wr && hit_flag;
    wire wr_ctrl  = bus_req.wr && hit_ctrl;
    wire wr_evclr = bus_req.wr && hit_evclr;
    wire wr_even  = bus_req.wr && hit_even;

    // write data trimmed to the pins that exist on the port
    wire [`PCED_DATA_W-1:0] wr_masked = bus_req.wdata & PORT_MASK[port_sel];

    // ------------------------------------------------------------
    // one detector and one flag bank per port
    // ------------------------------------------------------------
    for (genvar p = 0; p < `PCED_NPORT; p++) begin : g_port
        // clear strobe aimed at this port only
        wire clr_here = wr_flag && (port_sel == 2'(p));

        // synchronise and detect enabled edges
        pced_edge_detect #(
            .W         (PORT_W)
        ) u_edge (
            .core_clk  (core_clk),
            .nrst      (nrst),
            .pin_async (pin_vec[p]),
            .rise_en   (rise_en_reg[p]),
            .fall_en   (fall_en_reg[p]),
            .edge_hit  (edge_arr[p])
        );

        // sticky flags, set regardless of the master enable
        pced_flag_bank #(
            .W         (PORT_W),
            .MASK      (PORT_MASK[p])
        ) u_flag (
            .core_clk  (core_clk),
            .nrst      (nrst),
            .set_vec   (edge_arr[p]),
            .clr_wr    (clr_here),
            .wdata     (bus_req.wdata),
            .flags_reg (flag_arr[p]),
            .new_set   (new_arr[p])
        );

        // a port raised a fresh flag
        assign evt_set[p] = |new_arr[p];
    end

    // any flag of any port
    wire summary  = |flag_arr;
    // any enabled edge this cycle
    wire edge_any = |edge_arr;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // rising and falling enables, one byte per port
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rise_en_reg <= '0;
            fall_en_reg <= '0;
        end else begin
            if (wr_rise) begin
                rise_en_reg[port_sel] <= wr_masked;
            end
            if (wr_fall) begin
                fall_en_reg[port_sel] <= wr_masked;
            end
        end
    end

    // master enable and event enables
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            master_reg <= 1'b0;
            evt_en_reg <= `PCED_RST_EVT;
        end else begin
            if (wr_ctrl) begin
                master_reg <= bus_req.wdata[`PCED_CTRL_MIE];
            end
            if (wr_even) begin
                evt_en_reg <= bus_req.wdata[`PCED_NEVT-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // event status: fresh flag per port, write one to clear
    // ------------------------------------------------------------
    // the set wins over a clear in the same cycle
    wire [`PCED_NEVT-1:0] evt_clr =
        wr_evclr ? bus_req.wdata[`PCED_NEVT-1:0] : `PCED_RST_EVT;
    assign evt_stat_next = (evt_stat_reg & ~evt_clr) | evt_set;

    // sticky event bits
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            evt_stat_reg <= `PCED_RST_EVT;
        end else begin
            evt_stat_reg <= evt_stat_next;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // control and summary bytes
    wire [`PCED_DATA_W-1:0] ctrl_rd =
        `PCED_DATA_W'(master_reg) << `PCED_CTRL_MIE;
    wire [`PCED_DATA_W-1:0] periph_int_request_reg0_rd =
        `PCED_DATA_W'(summary) << `PCED_PERIPH_INT_REQUEST_REG0_SUM;
    wire [`PCED_DATA_W-1:0] evst_rd = `PCED_DATA_W'(evt_stat_reg);
    wire [`PCED_DATA_W-1:0] even_rd = `PCED_DATA_W'(evt_en_reg);

    // select; clear register and unmapped addresses read zero
    wire [`PCED_DATA_W-1:0] rd_mux =
        hit_rise ? rise_en_reg[port_sel] :
        hit_fall ? fall_en_reg[port_sel] :
        hit_flag ? flag_arr[port_sel]    :
        hit_ctrl ? ctrl_rd               :
        hit_periph_int_request_reg0 ? periph_int_request_reg0_rd               :
        hit_evst ? evst_rd               :
        hit_even ? even_rd               :
        `PCED_RST_BYTE;

    // answer stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rd_data_reg <= `PCED_RST_BYTE;
        end else begin
            rd_data_reg <= bus_req.rd ? rd_mux : `PCED_RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // interrupt and wake outputs
    // ------------------------------------------------------------
    // change request follows the flags, gated by the master
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            change_irq_reg <= 1'b0;
            evt_irq_reg    <= 1'b0;
        end else begin
            change_irq_reg <= master_reg && summary;
            evt_irq_reg    <= |(evt_stat_reg & evt_en_reg);
        end
    end

    // wake rises in the same edge that sets the flag
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= sleep_mode && master_reg && edge_any;
        end
    end

    // outputs straight from flip-flops
    assign rd_data    = rd_data_reg;
    assign change_irq = change_irq_reg;
    assign wake_req   = wake_reg;
    assign evt_irq    = evt_irq_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // an enabled edge on port a shows in its flags next cycle
    flag_set_a: assert property (
        (edge_arr[0] != '0) |=>
            ((flag_arr[0] & $past(edge_arr[0])) == $past(edge_arr[0])))
        else $error("edge did not set port a flag");

    // clearing write racing an edge leaves that flag set
    set_wins_a: assert property (
        (wr_flag && port_sel == 2'd0 && edge_arr[0] != '0) |=>
            ((flag_arr[0] & $past(edge_arr[0])) == $past(edge_arr[0])))
        else $error("edge lost during clearing write");

    // a clearing write with no edge ands the flags
    clear_zero_a: assert property (
        (wr_flag && port_sel == 2'd0 && edge_arr[0] == '0) |=>
            (flag_arr[0] == ($past(flag_arr[0]) & $past(bus_req.wdata))))
        else $error("port a flags not cleared by zero write");

    // without write or edge the port c flags do not move
    flag_hold_a: assert property (
        (!wr_flag && edge_arr[2] == '0) |=> $stable(flag_arr[2]))
        else $error("port c flag changed on its own");

    // request only follows an enabled master
    irq_gate_a: assert property (
        change_irq_reg |-> $past(master_reg))
        else $error("change request without master enable");

    // master off: flags set but no request
    master_off_a: assert property (
        (!master_reg && edge_any) ##1 !master_reg |->
            (summary && !change_irq_reg) ##1 !change_irq_reg)
        else $error("flags or request wrong with master off");

    // summary byte returns the or of all flags
    summary_read_a: assert property (
        (bus_req.rd && hit_periph_int_request_reg0) |=>
            (rd_data_reg[`PCED_PERIPH_INT_REQUEST_REG0_SUM] == $past(summary)))
        else $error("summary flag read wrong");

    // sleeping with master set, an edge wakes next cycle
    wake_sleep_a: assert property (
        (sleep_mode && master_reg && edge_any) |=> wake_reg)
        else $error("no wake on enabled edge");

    // flags are already set when wake appears
    wake_flag_a: assert property (
        wake_reg |-> summary)
        else $error("wake before flags updated");

    // a wake pulse needs master, sleep and an enabled edge
    wake_gate_a: assert property (
        wake_reg |-> ($past(master_reg) && $past(sleep_mode) && $past(edge_any)))
        else $error("wake without master, sleep and edge");

    // request rises one cycle after master and a flag
    irq_follow_a: assert property (
        (master_reg && summary) |=> change_irq_reg)
        else $error("no change request with master and flag");

    // request drops one cycle after master or flags go
    irq_clear_a: assert property (
        (!master_reg || !summary) |=> !change_irq_reg)
        else $error("change request stuck after clear");

    // rising enable write lands only on implemented port e pins
    pin_mask_a: assert property (
        wr_rise |=> (rise_en_reg[3] & ~PORT_MASK[3]) == '0)
        else $error("unimplemented port e enable bit set");

    // first cycle after reset master, flags and enables are clear
    reset_clear_a: assert property (
        !$past(nrst) |-> (!master_reg && flag_arr == '0 &&
                          rise_en_reg == '0 && fall_en_reg == '0))
        else $error("state not cleared by reset");

    // main scenarios
    wake_seen_c:   cover property (wake_reg);
    irq_seen_c:    cover property ($rose(change_irq_reg));
    race_seen_c:   cover property (wr_flag && edge_any);
    evt_irq_c:     cover property ($rose(evt_irq_reg));
endmodule : pced_top
`default_nettype wire

// File: logic/pced_cfg.svh
// constants of the pin change edge detector: widths, offsets, masks, resets
`ifndef PCED_CFG_SVH
`define PCED_CFG_SVH
// register bus and port geometry
`define PCED_ADDR_W     8
`define PCED_DATA_W     8
`define PCED_NPORT      4
`define PCED_NEVT       4
// register offsets (one byte per register)
`define PCED_GRP_RISE   6'h00
`define PCED_GRP_FALL   6'h01
`define PCED_GRP_FLAG   6'h02
`define PCED_ADR_CTRL   8'h0c
`define PCED_ADR_PERIPH_INT_REQUEST_REG0   8'h0d
`define PCED_ADR_EVST   8'h0e
`define PCED_ADR_EVCLR  8'h0f
`define PCED_ADR_EVEN   8'h10
// field positions
`define PCED_CTRL_MIE   0
`define PCED_PERIPH_INT_REQUEST_REG0_SUM   0
`define PCED_E_PIN      3
// implemented pins per port
`define PCED_MASK_A     8'hff
`define PCED_MASK_B     8'hff
`define PCED_MASK_C     8'hff
`define PCED_MASK_E     8'h08
// reset values and settle time of the sampler
`define PCED_RST_BYTE   8'h00
`define PCED_RST_EVT    4'h0
`define PCED_SETTLE     3
`endif

// File: logic/pced_pkg.sv
// types shared by the pin change edge detector files
`default_nettype none
`include "pced_cfg.svh"
package pced_pkg;
    // pins of the four ports as they arrive from the pads
    typedef struct packed {
        logic [7:0] a;   // port a pins
        logic [7:0] b;   // port b pins
        logic [7:0] c;   // port c pins
        logic       e3;  // single pin 3 of port e
    } pced_pins_type;
    // one register bus request
    typedef struct packed {
        logic [`PCED_ADDR_W-1:0] addr;   // byte address
        logic [`PCED_DATA_W-1:0] wdata;  // write data
        logic                    wr;     // write strobe
        logic                    rd;     // read strobe
    } pced_bus_req_type;
    // one byte per port
    typedef logic [`PCED_NPORT-1:0][`PCED_DATA_W-1:0] pced_port_arr_type;
endpackage : pced_pkg
`default_nettype wire

// File: logic/pced_edge_detect.sv
// pin synchroniser and enabled rise/fall detector for one port
`timescale 1ns/1ps
`default_nettype none
`include "pced_cfg.svh"
module pced_edge_detect #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] pin_async,
    input  wire logic [W-1:0] rise_en,
    input  wire logic [W-1:0] fall_en,
    output logic      [W-1:0] edge_hit
);
    if (W < 1) begin : g_bad_w
        $error("pced_edge_detect: W must be at least 1");
    end
    logic [W-1:0]             meta_reg;  // first sampler, read by sync_reg only
    logic [W-1:0]             sync_reg;  // clean pin level
    logic [W-1:0]             prev_reg;  // level one cycle earlier
    logic [`PCED_SETTLE-1:0]  vld_reg;   // history is trustworthy once full
    // two-stage sampling and the one-cycle-old copy
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
            vld_reg  <= '0;
        end else begin
            meta_reg <= pin_async;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
            vld_reg  <= {vld_reg[`PCED_SETTLE-2:0], 1'b1};
        end
    end
    // a pin high at reset release must not look like a rising edge
    wire          hist_ok = vld_reg[`PCED_SETTLE-1];
    wire [W-1:0]  rise    = sync_reg & ~prev_reg & rise_en;
    wire [W-1:0]  fall    = ~sync_reg & prev_reg & fall_en;
    // both enables give both directions, any mix of pins
    assign edge_hit = hist_ok ? (rise | fall) : '0;
endmodule : pced_edge_detect
`default_nettype wire

// File: logic/pced_flag_bank.sv
// sticky per-pin change flags of one port, cleared by writing zero
`timescale 1ns/1ps
`default_nettype none
module pced_flag_bank #(
    parameter int           W    = 8,
    parameter logic [W-1:0] MASK = '1
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] set_vec,
    input  wire logic         clr_wr,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] flags_reg,
    output logic      [W-1:0] new_set
);
    if (W < 1) begin : g_bad_w
        $error("pced_flag_bank: W must be at least 1");
    end
    logic [W-1:0] flags_next;  // next flag value
    // a zero written clears, a one keeps; an edge in the same cycle wins
    wire  [W-1:0] kept = clr_wr ? (flags_reg & wdata) : flags_reg;
    assign flags_next = (kept | set_vec) & MASK;
    // flags that were clear and are being set now
    assign new_set    = set_vec & ~flags_reg & MASK;
    // flag storage
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end
endmodule : pced_flag_bank
`default_nettype wire

// File: tb/pced_pin_model.sv
// pad-side model of the port pins: steady levels or pins flipping every cycle
`timescale 1ns/1ps
`default_nettype none
module pced_pin_model (
    input  wire logic                    core_clk,    // system clock
    input  wire pced_pkg::pced_pins_type level_set,   // steady levels asked by the bench
    input  wire pced_pkg::pced_pins_type toggle_mask, // pins that flip on every cycle
    output var  pced_pkg::pced_pins_type pins         // pad levels seen by the design
);
    // pads move on the falling edge, well away from the sampling edge
    always @(negedge core_clk) begin
        if (toggle_mask != '0) begin
            // flipping pins give an edge in every cycle
            pins <= pins ^ toggle_mask;
        end else begin
            // steady pads follow the asked levels
            pins <= level_set;
        end
    end
endmodule : pced_pin_model
`default_nettype wire

// File: tb/pced_bench.sv
// self-checking bench of the pin change edge detector
`timescale 1ns/1ps
`default_nettype none
`include "pced_cfg.svh"
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("BAD %s expected %h seen %h", what, exp, got); end end
module pced_bench;
    logic                       core_clk;       // 200 MHz clock
    logic                       nrst;           // synchronous reset, low active
    pced_pkg::pced_bus_req_type bus_req;        // register bus request
    logic                       sleep_mode;     // processor asleep
    logic [7:0]                 rd_data;        // read answer
    logic                       change_irq;     // change interrupt
    logic                       wake_req;       // wake pulse
    logic                       evt_irq;        // event interrupt
    pced_pkg::pced_pins_type    level_set;      // steady pad levels
    pced_pkg::pced_pins_type    toggle_mask;    // pads flipping each cycle
    pced_pkg::pced_pins_type    pins;           // pads as the design sees them
    int                         err_count = 0;  // mismatches
    int                         checks = 0;     // comparisons made
    int                         cycles = 0;     // run length guard
    int                         wake_cnt = 0;   // wake pulses seen
    int                         wake_base;      // wake count at scenario start
    logic [7:0]                 rv;             // scratch read value
    logic [7:0]                 rise_v [4];     // rise enables per port
    logic [7:0]                 exp_v [4];      // flags expected per port

    pced_top #(.PORT_W(8)) pced_top_i (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .pins       (pins),
        .bus_req    (bus_req),
        .sleep_mode (sleep_mode),
        .rd_data    (rd_data),
        .change_irq (change_irq),
        .wake_req   (wake_req),
        .evt_irq    (evt_irq)
    );
    pced_pin_model pced_pin_model_i (
        .core_clk    (core_clk),
        .level_set   (level_set),
        .toggle_mask (toggle_mask),
        .pins        (pins)
    );

    // free-running clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // count wake pulses and cut a hung run short
    always @(posedge core_clk) begin
        if (wake_req === 1'b1) begin
            wake_cnt <= wake_cnt + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_count++;
            wrap_up();
        end
    end

    // register address from group and port
    function automatic logic [7:0] adr(input logic [5:0] g, input logic [1:0] p);
        return {g, p};
    endfunction : adr
    // one write cycle, then an idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
    endtask : wr
    // one read cycle; data stand in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        d = rd_data;
    endtask : rd
    // read and compare
    task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        `CHK(what, exp, d)
    endtask : chk_rd
    // room for sampler, detector and flag update
    task automatic settle();
        repeat (8) @(posedge core_clk);
        #1;
    endtask : settle
    // reset held for twelve cycles
    task automatic do_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask : do_reset
    // closing report
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // main sequence
    initial begin
        rise_v = '{8'h0f, 8'h55, 8'h81, 8'hff};
        exp_v = '{8'h0f, 8'h55, 8'h81, 8'h08};
        nrst = 1'b0;
        bus_req = '0;
        sleep_mode = 1'b0;
        level_set = '0;
        toggle_mask = '0;
        do_reset();
        for (int i = 0; i <= 16; i++) begin
            chk_rd("reset value", i[7:0], 8'h00);
        end
        chk_rd("unmapped", 8'h20, 8'h00);
        `CHK("irq at reset", 1'b0, change_irq)
        $display("test reset values done");
        // per-port enables, every port raised at once
        for (int p = 0; p < 4; p++) begin
            wr(adr(`PCED_GRP_RISE, p[1:0]), rise_v[p]);
        end
        wr(adr(`PCED_GRP_FALL, 2'd0), 8'hf0);
        chk_rd("rise e readback", adr(`PCED_GRP_RISE, 2'd3), 8'h08);
        level_set <= '{a: 8'hff, b: 8'hff, c: 8'hff, e3: 1'b1};
        settle();
        for (int p = 0; p < 4; p++) begin
            chk_rd("flags after rise", adr(`PCED_GRP_FLAG, p[1:0]), exp_v[p]);
        end
        chk_rd("summary set", `PCED_ADR_PERIPH_INT_REQUEST_REG0, 8'h01);
        `CHK("irq without master", 1'b0, change_irq)
        level_set <= '0;
        settle();
        chk_rd("flags a after fall", adr(`PCED_GRP_FLAG, 2'd0), 8'hff);
        chk_rd("flags b still set", adr(`PCED_GRP_FLAG, 2'd1), 8'h55);
        $display("test edge enables done");
        // master enable, then clearing by masked writes
        wr(`PCED_ADR_CTRL, 8'h01);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("irq with master", 1'b1, change_irq)
        wr(adr(`PCED_GRP_FLAG, 2'd0), 8'hf0);
        chk_rd("partial clear", adr(`PCED_GRP_FLAG, 2'd0), 8'hf0);
        for (int p = 0; p < 4; p++) begin
            rd(adr(`PCED_GRP_FLAG, p[1:0]), rv);
            wr(adr(`PCED_GRP_FLAG, p[1:0]), rv ^ 8'hff);
        end
        wr(adr(`PCED_GRP_FLAG, 2'd0), 8'hff);
        chk_rd("ones do not set", adr(`PCED_GRP_FLAG, 2'd0), 8'h00);
        chk_rd("summary clear", `PCED_ADR_PERIPH_INT_REQUEST_REG0, 8'h00);
        `CHK("irq after clear", 1'b0, change_irq)
        $display("test master and clear done");
        // both directions on one pin of port c, master off
        wr(`PCED_ADR_CTRL, 8'h00);
        wr(adr(`PCED_GRP_FALL, 2'd2), 8'h01);
        for (int k = 0; k < 2; k++) begin
            level_set.c <= (k == 0) ? 8'h01 : 8'h00;
            settle();
            chk_rd("both edges", adr(`PCED_GRP_FLAG, 2'd2), 8'h01);
            `CHK("no irq master off", 1'b0, change_irq)
            wr(adr(`PCED_GRP_FLAG, 2'd2), 8'h00);
        end
        $display("test both edges done");
        // clearing write while the pin keeps changing, read right behind it
        wr(adr(`PCED_GRP_FALL, 2'd0), 8'hf1);
        toggle_mask <= '{a: 8'h01, b: 8'h00, c: 8'h00, e3: 1'b0};
        settle();
        @(posedge core_clk);
        bus_req <= '{addr: adr(`PCED_GRP_FLAG, 2'd0), wdata: 8'h00, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req <= '{addr: adr(`PCED_GRP_FLAG, 2'd0), wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        `CHK("edge beats clear", 8'h01, rd_data)
        toggle_mask <= '0;
        settle();
        wr(adr(`PCED_GRP_FLAG, 2'd0), 8'h00);
        chk_rd("clear when quiet", adr(`PCED_GRP_FLAG, 2'd0), 8'h00);
        $display("test clear race done");
        // wake from sleep with master on, none with master off
        wr(`PCED_ADR_CTRL, 8'h01);
        sleep_mode <= 1'b1;
        wake_base = wake_cnt;
        level_set.a <= 8'h01;
        rv = 8'h00;
        for (int i = 0; i < 20 && rv == 8'h00; i++) begin
            @(posedge core_clk);
            #1;
            if (wake_req === 1'b1) begin
                rv = 8'h01;
            end
        end
        `CHK("wake seen", 8'h01, rv)
        chk_rd("flag at wake", adr(`PCED_GRP_FLAG, 2'd0), 8'h01);
        `CHK("wake pulses", 1, wake_cnt - wake_base)
        wr(`PCED_ADR_CTRL, 8'h00);
        wr(adr(`PCED_GRP_FLAG, 2'd0), 8'h00);
        wake_base = wake_cnt;
        level_set.a <= 8'h00;
        settle();
        `CHK("no wake master off", 0, wake_cnt - wake_base)
        chk_rd("flag master off", adr(`PCED_GRP_FLAG, 2'd0), 8'h01);
        sleep_mode <= 1'b0;
        $display("test sleep wake done");
        // port events: raise, mask, clear
        wr(adr(`PCED_GRP_FLAG, 2'd0), 8'h00);
        wr(`PCED_ADR_EVCLR, 8'h0f);
        chk_rd("event status clear", `PCED_ADR_EVST, 8'h00);
        wr(`PCED_ADR_EVEN, 8'h01);
        level_set.a <= 8'h01;
        settle();
        chk_rd("event status", `PCED_ADR_EVST, 8'h01);
        `CHK("event irq", 1'b1, evt_irq)
        wr(`PCED_ADR_EVEN, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("event irq masked", 1'b0, evt_irq)
        wr(`PCED_ADR_EVCLR, 8'h01);
        chk_rd("event cleared", `PCED_ADR_EVST, 8'h00);
        chk_rd("clear reads zero", `PCED_ADR_EVCLR, 8'h00);
        $display("test events done");
        // second reset in mid-run wipes enables and master
        wr(`PCED_ADR_CTRL, 8'h01);
        do_reset();
        chk_rd("rise a after reset", adr(`PCED_GRP_RISE, 2'd0), 8'h00);
        chk_rd("fall a after reset", adr(`PCED_GRP_FALL, 2'd0), 8'h00);
        chk_rd("master after reset", `PCED_ADR_CTRL, 8'h00);
        $display("test second reset done");
        wrap_up();
    end
endmodule : pced_bench
`default_nettype wire
